// ### logic/ecic_pkg.sv
// Shared constants and types for the capture input control block
package ecic_pkg;
	localparam int ADDR_W = 10;
	localparam int NCH = 4;
	localparam int NPIN = 8;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CAP = 8'h90;
	localparam logic [7:0] IDX_ACCUM_COUNT_HIGH = 8'ha4;
	localparam logic [7:0] IDX_ACCUM_COUNT_LOW = 8'ha5;
	localparam logic [7:0] IDX_FORCE = 8'ha6;
	localparam logic [7:0] IDX_PACEN = 8'ha8;
	localparam logic [7:0] IDX_DLY = 8'ha9;
	localparam logic [7:0] IDX_OVW = 8'haa;
	localparam logic [7:0] IDX_SYS = 8'hab;
	localparam logic [7:0] IDX_TST = 8'had;
	localparam logic [7:0] IDX_PORT = 8'hae;
	localparam logic [7:0] IDX_DDR = 8'haf;
	localparam logic [7:0] IDX_ACCUMULATOR_B_CONTROL = 8'hb0;
	localparam logic [7:0] IDX_ACCUMULATOR_B_FLAGS = 8'hb1;
	localparam logic [7:0] IDX_PA1H = 8'hb4;
	localparam logic [7:0] IDX_PA0H = 8'hb5;
	localparam logic [7:0] IDX_HOLD = 8'hb8;
	// Field positions
	localparam int FORCE_BIT = 4;
	localparam int ACCUM_B_ENABLE_BIT = 6;
	localparam int OVI_BIT = 1;
	localparam int OVF_BIT = 1;
	localparam int BYP_BIT = 1;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Delay filter lengths in module clock cycles
	localparam logic [1:0] DLY_OFF = 2'h0;
	localparam logic [10:0] DLY_256 = 11'h100;
	localparam logic [10:0] DLY_512 = 11'h200;
	localparam logic [10:0] DLY_1024 = 11'h400;

	typedef enum logic {FLT_IDLE = 1'b0, FLT_WAIT = 1'b1} ecic_flt_t;

	typedef struct packed {
		logic [3:0] share;
		logic       flag_on_latch_mode;
		logic       byte_acc_saturate;
		logic       holding_buffer_enable;
		logic       latch_not_queue;
	} ecic_sys_t;

	function automatic logic [10:0] dly_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h1: return DLY_256;
			2'h2: return DLY_512;
			default: return DLY_1024;
		endcase
	endfunction

	function automatic logic [7:0] pair_idx(input logic [7:0] base,
		input int c);
		return base + 8'(2 * c);
	endfunction
endpackage

// ### logic/ecic_top.sv
// Capture input control: delay filter, buffering, accumulator B, port
// Behaviour
// RL1: Enabled filter counts delay after valid edge
// RL2: Pulse only if level flipped after delay
// RL3: Counter self-clears; edges spaced beyond delay
// RL4: Select 00 bypass, 256, 512, 1024 cycles
// RL5: Read or latched capture is empty
// RL6: No-overwrite bit writes only empty registers
// RL7: System control write-once in normal mode
// RL8: Share bit routes pin x to channel y
// RL9: Flag-on-latch in queue flags holding loads
// RL10: Byte accumulators wrap or saturate at ff
// RL11: Buffer disable stops latch and queue
// RL12: Force latch copies captures and accumulators
// RL13: Queue mode shifts capture into holding
// RL14: Modulus zero latches then clears accumulators
// RL15: Test bypass bit writable in special mode
// RL16: Port read returns pin or latch
// RL17: Software frees line 7 from compare 7; no such control here, oc_enable[7] always forces line 7
// RL18: Inputs held over two clock periods
// RL19: Direction bits; compare forces output
// RL20: Accumulator B cascades bytes from channel 0
// RL21: B runs without timer; irq when enabled
// RL22: B overflow flag set on wrap, cleared
// RL23: Forced latch clears byte accumulators
// RL24: Two-stage synchroniser before edge logic
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ecic_top (
	// Clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// AXI4-Lite slave
	input  wire logic [ecic_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [ecic_pkg::ADDR_W-1:0] araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	// Timer port pins
	input  wire logic [7:0]                  port_pin_in,
	output logic [7:0]                       port_pin_out,
	output logic [7:0]                       port_pin_oe,
	// Main timer and modulus counter side
	input  wire logic [15:0]                 timer_count,
	input  wire logic                        modulus_zero,
	input  wire logic                        special_mode_low,
	input  wire logic                        fast_flag_clear,
	input  wire logic [7:0]                  oc_enable,
	input  wire logic [7:0]                  oc_level,
	// Results
	output logic [3:0]                       capture_flags,
	output logic                             divider_chain_bypass,
	output logic                             accum_b_irq
);
	localparam int NCH = ecic_pkg::NCH;
	localparam int NPIN = ecic_pkg::NPIN;

	logic [7:0]  sync1_r, sync2_r, prev_r, ev_flt_r, lvl_before_r;
	ecic_pkg::ecic_flt_t fst_r [NPIN];
	logic [10:0] cnt_r [NPIN];
	logic [15:0] cap_r [NCH];
	logic [15:0] hold_r [NCH];
	logic [3:0]  cap_full_r, hold_full_r;
	logic [7:0]  dly_r, novw_r, pacen_r, timer_port_data_r, timer_port_direction_r, accumulator_b_control_r;
	ecic_pkg::ecic_sys_t sys_r;
	logic        sys_written_r, ovf_r;
	logic [7:0]  byte_accumulator_0_r, byte_accumulator_1_r, pah0_r, pah1_r;
	logic        aw_got_r, w_got_r;
	logic [7:0]  aw_idx_r, wdata_r;
	logic        wstrb0_r;

	// Bus decode
	wire         aw_take = awvalid & awready;
	wire         w_take = wvalid & wready;
	wire         ar_take = arvalid & arready;
	wire         do_wr = aw_got_r & w_got_r & ~bvalid;
	wire  [7:0]  ar_idx = araddr[9:2];
	wire         wr_b = do_wr & wstrb0_r;
	logic [31:0] rd_word;
	logic        rd_hit, wr_hit;
	logic [3:0]  rd_cap, rd_hold;

	// Filter and channel routing
	wire  [7:0]  edge_raw = sync2_r ^ prev_r;
	wire  [1:0]  dly_sel = dly_r[1:0];
	wire         flt_on = dly_sel != ecic_pkg::DLY_OFF;
	wire  [10:0] dly_last = ecic_pkg::dly_cycles(dly_sel) - 11'h001;
	wire  [7:0]  ev_pin = flt_on ? ev_flt_r : edge_raw;
	wire  [3:0]  ev_ch = (sys_r.share & ev_pin[7:4])
		| (~sys_r.share & ev_pin[3:0]); // RL8

	// Buffering modes
	wire         queue = sys_r.holding_buffer_enable
		& ~sys_r.latch_not_queue; // RL11
	wire         force_wr = wr_b & aw_idx_r == ecic_pkg::IDX_FORCE
		& wdata_r[ecic_pkg::FORCE_BIT];
	wire         latch_ev = sys_r.holding_buffer_enable
		& sys_r.latch_not_queue & (modulus_zero | force_wr); // RL12 RL14
	wire  [3:0]  hold_ok = ~novw_r[3:0] | ~hold_full_r; // RL6
	wire  [3:0]  cap_ok = ~novw_r[3:0] | ~cap_full_r; // RL6
	wire  [3:0]  q_shift = {4{queue}} & ev_ch & cap_full_r & hold_ok;
	wire  [3:0]  flag_nxt = queue & sys_r.flag_on_latch_mode
		? q_shift : ev_ch; // RL9

	// Accumulators
	wire         accum_b_enable = accumulator_b_control_r[ecic_pkg::ACCUM_B_ENABLE_BIT];
	wire         sat = sys_r.byte_acc_saturate & ~accum_b_enable;
	wire         inc0 = ev_ch[0] & (accum_b_enable | pacen_r[0]); // RL20
	wire         inc1 = accum_b_enable ? inc0 & byte_accumulator_0_r == ecic_pkg::BYTE_MAX
		: ev_ch[1] & pacen_r[1]; // RL20
	wire         wrap1 = inc1 & byte_accumulator_1_r == ecic_pkg::BYTE_MAX & ~sat;
	wire         wr_accum_count_high = wr_b & aw_idx_r == ecic_pkg::IDX_ACCUM_COUNT_HIGH;
	wire         wr_accum_count_low = wr_b & aw_idx_r == ecic_pkg::IDX_ACCUM_COUNT_LOW;
	wire         pacn_touch = fast_flag_clear & (wr_accum_count_high | wr_accum_count_low
		| (ar_take & (ar_idx == ecic_pkg::IDX_ACCUM_COUNT_HIGH
		| ar_idx == ecic_pkg::IDX_ACCUM_COUNT_LOW)));
	wire         ovf_clr = pacn_touch | (wr_b & aw_idx_r
		== ecic_pkg::IDX_ACCUMULATOR_B_FLAGS & wdata_r[ecic_pkg::OVF_BIT]); // RL22
	wire  [7:0]  out_dir = timer_port_direction_r | oc_enable; // RL19
	wire  [7:0]  port_rd = (out_dir & timer_port_data_r) | (~out_dir & sync2_r);

	function automatic logic [7:0] acc_step(input logic [7:0] v,
		input logic s);
		if (s && v == ecic_pkg::BYTE_MAX)
			return v; // RL10
		return v + 8'h01;
	endfunction

	always_comb
	begin
		rd_word = 32'h0;
		rd_hit = 1'b1;
		unique case (ar_idx)
			ecic_pkg::IDX_ACCUM_COUNT_HIGH: rd_word[7:0] = byte_accumulator_1_r;
			ecic_pkg::IDX_ACCUM_COUNT_LOW: rd_word[7:0] = byte_accumulator_0_r;
			ecic_pkg::IDX_FORCE: rd_word[7:0] = ecic_pkg::RST_REG;
			ecic_pkg::IDX_PACEN: rd_word[7:0] = pacen_r;
			ecic_pkg::IDX_DLY: rd_word[7:0] = dly_r;
			ecic_pkg::IDX_OVW: rd_word[7:0] = novw_r;
			ecic_pkg::IDX_SYS: rd_word[7:0] = sys_r;
			ecic_pkg::IDX_TST: rd_word[ecic_pkg::BYP_BIT] =
				divider_chain_bypass;
			ecic_pkg::IDX_PORT: rd_word[7:0] = port_rd; // RL16
			ecic_pkg::IDX_DDR: rd_word[7:0] = timer_port_direction_r;
			ecic_pkg::IDX_ACCUMULATOR_B_CONTROL: rd_word[7:0] = accumulator_b_control_r;
			ecic_pkg::IDX_ACCUMULATOR_B_FLAGS: rd_word[ecic_pkg::OVF_BIT] = ovf_r;
			ecic_pkg::IDX_PA1H: rd_word[7:0] = pah1_r;
			ecic_pkg::IDX_PA0H: rd_word[7:0] = pah0_r;
			default:
			begin
				rd_hit = 1'b0;
				for (int c = 0; c < NCH; c++)
				begin
					if (ar_idx == ecic_pkg::pair_idx(ecic_pkg::IDX_CAP, c))
					begin
						rd_word[15:0] = cap_r[c];
						rd_hit = 1'b1;
					end
					if (ar_idx == ecic_pkg::pair_idx(ecic_pkg::IDX_HOLD, c))
					begin
						rd_word[15:0] = hold_r[c];
						rd_hit = 1'b1;
					end
				end
			end
		endcase
	end

	always_comb
	begin
		wr_hit = 1'b0;
		for (int c = 0; c < NCH; c++)
		begin
			rd_cap[c] = ar_take
				& ar_idx == ecic_pkg::pair_idx(ecic_pkg::IDX_CAP, c);
			rd_hold[c] = ar_take
				& ar_idx == ecic_pkg::pair_idx(ecic_pkg::IDX_HOLD, c);
			if (aw_idx_r == ecic_pkg::pair_idx(ecic_pkg::IDX_CAP, c)
				|| aw_idx_r == ecic_pkg::pair_idx(ecic_pkg::IDX_HOLD, c))
				wr_hit = 1'b1;
		end
		if (aw_idx_r >= ecic_pkg::IDX_ACCUM_COUNT_HIGH
			&& aw_idx_r <= ecic_pkg::IDX_PA0H
			&& aw_idx_r != 8'ha7 && aw_idx_r != 8'hac
			&& aw_idx_r != 8'hb2 && aw_idx_r != 8'hb3)
			wr_hit = 1'b1;
	end

	// AXI4-Lite write channel; both halves are taken in either order
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_idx_r <= 8'h00;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
			bvalid <= 1'b0;
			bresp <= ecic_pkg::RESP_OKAY;
		end
		else
		begin
			awready <= ~aw_got_r & ~aw_take & ~bvalid & ~do_wr;
			wready <= ~w_got_r & ~w_take & ~bvalid & ~do_wr;
			if (aw_take)
			begin
				aw_got_r <= 1'b1;
				aw_idx_r <= awaddr[9:2];
			end
			if (w_take)
			begin
				w_got_r <= 1'b1;
				wdata_r <= wdata[7:0];
				wstrb0_r <= wstrb[0];
			end
			if (do_wr)
			begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? ecic_pkg::RESP_OKAY
					: ecic_pkg::RESP_SLVERR;
			end
			if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read channel; answer one cycle after the address is taken
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= ecic_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_hit ? ecic_pkg::RESP_OKAY : ecic_pkg::RESP_SLVERR;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
		else if (!rvalid)
			arready <= 1'b1;
	end

	// Synchroniser, edge detector and delay filter per pin
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
			prev_r <= 8'h00;
			ev_flt_r <= 8'h00;
			lvl_before_r <= 8'h00;
			for (int i = 0; i < NPIN; i++)
			begin
				fst_r[i] <= ecic_pkg::FLT_IDLE;
				cnt_r[i] <= 11'h000;
			end
		end
		else
		begin
			sync1_r <= port_pin_in; // RL24
			sync2_r <= sync1_r; // RL24
			prev_r <= sync2_r;
			for (int i = 0; i < NPIN; i++)
			begin
				ev_flt_r[i] <= 1'b0;
				unique case (fst_r[i])
					ecic_pkg::FLT_IDLE:
						if (flt_on && edge_raw[i])
						begin
							fst_r[i] <= ecic_pkg::FLT_WAIT; // RL1
							lvl_before_r[i] <= prev_r[i];
						end
					ecic_pkg::FLT_WAIT:
						if (!flt_on)
						begin
							fst_r[i] <= ecic_pkg::FLT_IDLE;
							cnt_r[i] <= 11'h000;
						end
						else if (cnt_r[i] >= dly_last) // RL4
						begin
							fst_r[i] <= ecic_pkg::FLT_IDLE;
							cnt_r[i] <= 11'h000; // RL3
							ev_flt_r[i] <= sync2_r[i] ^ lvl_before_r[i]; // RL2
						end
						else
							cnt_r[i] <= cnt_r[i] + 11'h001; // RL1
				endcase
			end
		end
	end

	// Control registers
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			dly_r <= ecic_pkg::RST_REG;
			novw_r <= ecic_pkg::RST_REG;
			pacen_r <= ecic_pkg::RST_REG;
			timer_port_data_r <= ecic_pkg::RST_REG;
			timer_port_direction_r <= ecic_pkg::RST_REG;
			accumulator_b_control_r <= ecic_pkg::RST_REG;
			sys_r <= ecic_pkg::RST_REG;
			sys_written_r <= 1'b0;
			divider_chain_bypass <= 1'b0;
		end
		else if (wr_b)
		begin
			unique case (aw_idx_r)
				ecic_pkg::IDX_DLY: dly_r <= wdata_r;
				ecic_pkg::IDX_OVW: novw_r <= wdata_r;
				ecic_pkg::IDX_PACEN: pacen_r <= wdata_r;
				ecic_pkg::IDX_PORT: timer_port_data_r <= wdata_r;
				ecic_pkg::IDX_DDR: timer_port_direction_r <= wdata_r;
				ecic_pkg::IDX_ACCUMULATOR_B_CONTROL: accumulator_b_control_r <= wdata_r;
				ecic_pkg::IDX_SYS:
					if (!special_mode_low || !sys_written_r) // RL7
					begin
						sys_r <= wdata_r;
						sys_written_r <= 1'b1;
					end
				ecic_pkg::IDX_TST:
					if (!special_mode_low) // RL15
						divider_chain_bypass <= wdata_r[ecic_pkg::BYP_BIT];
				default: ;
			endcase
		end
	end

	// Capture and holding registers; later assignments take priority
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cap_full_r <= 4'h0;
			hold_full_r <= 4'h0;
			capture_flags <= 4'h0;
			for (int c = 0; c < NCH; c++)
			begin
				cap_r[c] <= 16'h0000;
				hold_r[c] <= 16'h0000;
			end
		end
		else
		begin
			capture_flags <= flag_nxt; // RL9
			for (int c = 0; c < NCH; c++)
			begin
				if (rd_cap[c])
					cap_full_r[c] <= 1'b0; // RL5
				if (rd_hold[c])
					hold_full_r[c] <= 1'b0; // RL5
				if (latch_ev && hold_ok[c])
				begin
					hold_r[c] <= cap_r[c]; // RL14
					hold_full_r[c] <= 1'b1;
					cap_full_r[c] <= 1'b0; // RL5
				end
				if (q_shift[c])
				begin
					hold_r[c] <= cap_r[c]; // RL13
					hold_full_r[c] <= 1'b1;
				end
				if (ev_ch[c] && (q_shift[c] || cap_ok[c]))
				begin
					cap_r[c] <= timer_count; // RL13
					cap_full_r[c] <= 1'b1;
				end
			end
		end
	end

	// Byte accumulators, accumulator B and port pins
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			byte_accumulator_0_r <= 8'h00;
			byte_accumulator_1_r <= 8'h00;
			pah0_r <= 8'h00;
			pah1_r <= 8'h00;
			ovf_r <= 1'b0;
			accum_b_irq <= 1'b0;
			port_pin_out <= 8'h00;
			port_pin_oe <= 8'h00;
		end
		else
		begin
			if (inc0)
				byte_accumulator_0_r <= acc_step(byte_accumulator_0_r, sat); // RL10
			if (inc1)
				byte_accumulator_1_r <= acc_step(byte_accumulator_1_r, sat); // RL10
			if (latch_ev)
			begin
				pah0_r <= byte_accumulator_0_r;
				pah1_r <= byte_accumulator_1_r;
				byte_accumulator_0_r <= 8'h00; // RL23
				byte_accumulator_1_r <= 8'h00; // RL14
			end
			if (wr_accum_count_low)
				byte_accumulator_0_r <= wdata_r;
			if (wr_accum_count_high)
				byte_accumulator_1_r <= wdata_r;
			ovf_r <= wrap1 | (ovf_r & ~ovf_clr); // RL22
			accum_b_irq <= ovf_r & accumulator_b_control_r[ecic_pkg::OVI_BIT]; // RL21
			port_pin_out <= (oc_enable & oc_level)
				| (~oc_enable & timer_port_data_r); // RL16
			port_pin_oe <= out_dir; // RL19
		end
	end

	chk_flt_bound: assert property (@(posedge mclk) disable iff (rst) // RL4
		fst_r[0] == ecic_pkg::FLT_WAIT && flt_on |-> cnt_r[0] <= dly_last)
		else $error("delay counter ran past its length");
	chk_flt_reject: assert property (@(posedge mclk) disable iff (rst) // RL2
		ev_flt_r[0] |-> prev_r[0] != $past(lvl_before_r[0]))
		else $error("filtered pulse without level change");
	chk_flt_clear: assert property (@(posedge mclk) disable iff (rst) // RL3
		ev_flt_r[0] |-> cnt_r[0] == 11'h000
		&& fst_r[0] == ecic_pkg::FLT_IDLE)
		else $error("delay counter not cleared after pulse");
	chk_sys_once: assert property (@(posedge mclk) disable iff (rst) // RL7
		special_mode_low && sys_written_r |=> $stable(sys_r))
		else $error("system control rewritten in normal mode");
	chk_novw_keep: assert property (@(posedge mclk) disable iff (rst) // RL6
		novw_r[0] && cap_full_r[0] && hold_full_r[0]
		|=> $stable(cap_r[0]) && $stable(hold_r[0]))
		else $error("protected capture overwritten");
	chk_acc_sat: assert property (@(posedge mclk) disable iff (rst) // RL10
		sat && byte_accumulator_0_r == ecic_pkg::BYTE_MAX && !latch_ev && !wr_accum_count_low
		|=> byte_accumulator_0_r == ecic_pkg::BYTE_MAX)
		else $error("saturated accumulator moved");
	chk_latch_zero: assert property (@(posedge mclk) disable iff (rst) // RL14
		latch_ev && !wr_accum_count_low && !wr_accum_count_high
		|=> byte_accumulator_0_r == 8'h00 && byte_accumulator_1_r == 8'h00)
		else $error("accumulators not cleared by latch");
	chk_b_irq: assert property (@(posedge mclk) disable iff (rst) // RL22
		wrap1 |=> ovf_r ##1 accum_b_irq == accumulator_b_control_r[ecic_pkg::OVI_BIT])
		else $error("overflow flag or interrupt missing");
endmodule

// ### verification/ecic_pin_model.sv
// Pin-side model: external sources on the timer port lines
`timescale 1ns/1ps
module ecic_pin_model (
	// Clock
	input  wire logic       mclk,
	// Design side of the port
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// Resolved line levels
	output logic [7:0]      pin_wire
);
	logic [7:0] drv_r = 8'h00;

	// A line the design drives shows its level; the others show ours
	assign pin_wire = (pin_oe & pin_out) | (~pin_oe & drv_r);

	// Pulses are far wider than two clocks so the synchroniser keeps them
	task automatic pulse(input int ch, input int len);
		@(posedge mclk);
		drv_r[ch] <= ~drv_r[ch];
		repeat (len) @(posedge mclk);
		drv_r[ch] <= ~drv_r[ch];
	endtask

	task automatic toggle(input int ch);
		@(posedge mclk);
		drv_r[ch] <= ~drv_r[ch];
	endtask

	task automatic set_all(input logic [7:0] v);
		@(posedge mclk);
		drv_r <= v;
	endtask
endmodule

// ### verification/ecic_top_tb.sv
// Self-checking bench for the capture input control block
`timescale 1ns/1ps
module ecic_top_tb;
	localparam int LIMIT = 20000;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [9:0]  awaddr = 10'h000;
	logic [9:0]  araddr = 10'h000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic [15:0] timer_count = 16'h0000;
	logic        modulus_zero = 1'b0;
	logic        special_mode_low = 1'b1;
	logic        fast_flag_clear = 1'b0;
	logic [7:0]  oc_enable = 8'h00;
	logic [7:0]  oc_level = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] rdata;
	logic [1:0]  bresp, rresp, rs;
	logic [7:0]  pin_in, pin_out, pin_oe;
	logic [3:0]  capture_flags;
	logic        divider_chain_bypass, accum_b_irq;
	logic [15:0] rv;
	int          n_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	int          flg0 = 0;
	int          n;

	always #4 mclk = ~mclk;

	ecic_top uut (
		.mclk(mclk), .rst(rst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.port_pin_in(pin_in), .port_pin_out(pin_out),
		.port_pin_oe(pin_oe), .timer_count(timer_count),
		.modulus_zero(modulus_zero), .special_mode_low(special_mode_low),
		.fast_flag_clear(fast_flag_clear), .oc_enable(oc_enable),
		.oc_level(oc_level), .capture_flags(capture_flags),
		.divider_chain_bypass(divider_chain_bypass),
		.accum_b_irq(accum_b_irq)
	);

	ecic_pin_model pm (
		.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_wire(pin_in)
	);

	task automatic end_of_test();
		$display("Compares %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog; also counts channel 0 flag pulses, which stand one cycle
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (capture_flags[0] === 1'b1)
			flg0 <= flg0 + 1;
		if (cyc == LIMIT)
		begin
			n_errors = n_errors + 1;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bit ah;
		bit wh;
		@(posedge mclk);
		awaddr <= {idx, 2'b00};
		wdata <= {d, d, d, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ah && wh))
		begin
			@(posedge mclk);
			ah = ah | (awvalid & awready);
			wh = wh | (wvalid & wready);
			awvalid <= awvalid & ~awready;
			wvalid <= wvalid & ~wready;
		end
		do
			@(posedge mclk);
		while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx);
		@(posedge mclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge mclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
			@(posedge mclk);
		while (rvalid !== 1'b1);
		rv = rdata[15:0];
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [15:0] exp,
		input string what);
		rd(idx);
		chk(what, exp, rv);
	endtask

	task automatic mz();
		@(posedge mclk);
		modulus_zero <= 1'b1;
		@(posedge mclk);
		modulus_zero <= 1'b0;
	endtask

	initial
	begin
		idle(20);
		rst <= 1'b0;
		idle(2);
		rdc(ecic_pkg::IDX_PORT, 16'h0000, "port reset");
		rd(8'h80);
		chk("unmapped rresp", 16'(ecic_pkg::RESP_SLVERR), 16'(rs));
		wr(8'h81, 8'h55);
		chk("unmapped bresp", 16'(ecic_pkg::RESP_SLVERR), 16'(rs));
		// Normal mode: one control write only, test bit locked
		wr(ecic_pkg::IDX_SYS, 8'h04);
		wr(ecic_pkg::IDX_SYS, 8'h08);
		rdc(ecic_pkg::IDX_SYS, 16'h0004, "sys once");
		wr(ecic_pkg::IDX_TST, 8'h02);
		chk("bypass normal", 16'h0, 16'(divider_chain_bypass));
		special_mode_low <= 1'b0;
		wr(ecic_pkg::IDX_TST, 8'h02);
		idle(2);
		chk("bypass special", 16'h1, 16'(divider_chain_bypass));
		// Saturating byte count from fe, two pulses (four edges), three edges past the top
		wr(ecic_pkg::IDX_SYS, 8'h04);
		wr(ecic_pkg::IDX_PACEN, 8'h01);
		wr(ecic_pkg::IDX_ACCUM_COUNT_LOW, 8'hfe);
		pm.pulse(0, 10);
		pm.pulse(0, 10);
		idle(8);
		rdc(ecic_pkg::IDX_ACCUM_COUNT_LOW, 16'h00ff, "acc0 saturate");
		// Channel 0 follows pin 4 while shared; its own pin is muted
		wr(ecic_pkg::IDX_SYS, 8'h10);
		n = flg0;
		pm.toggle(4);
		idle(8);
		chk("shared pin", 16'(n + 1), 16'(flg0));
		pm.toggle(0);
		idle(8);
		chk("own pin muted", 16'(n + 1), 16'(flg0));
		wr(ecic_pkg::IDX_SYS, 8'h00);
		// Every delay select, flag must not come early or late
		for (int s = 0; s < 4; s++)
		begin
			wr(ecic_pkg::IDX_DLY, 8'(s));
			n = flg0;
			pm.toggle(0);
			idle((s == 0) ? 0 : (128 << s) - 6);
			chk("early flag", 16'(n), 16'(flg0));
			idle(14);
			chk("filtered flag", 16'(n + 1), 16'(flg0));
		end
		wr(ecic_pkg::IDX_DLY, 8'h01);
		n = flg0;
		pm.pulse(0, 20);
		idle(300);
		chk("narrow pulse", 16'(n), 16'(flg0));
		// Queue mode, flag on holding load, no overwrite on channel 0
		wr(ecic_pkg::IDX_DLY, 8'h00);
		wr(ecic_pkg::IDX_OVW, 8'h01);
		wr(ecic_pkg::IDX_SYS, 8'h0a);
		rd(ecic_pkg::IDX_CAP);
		rd(ecic_pkg::IDX_HOLD);
		n = flg0;
		timer_count <= 16'h1111;
		pm.toggle(0);
		idle(8);
		chk("no flag first", 16'(n), 16'(flg0));
		timer_count <= 16'h2222;
		pm.toggle(0);
		idle(8);
		chk("flag on load", 16'(n + 1), 16'(flg0));
		timer_count <= 16'h3333;
		pm.toggle(0);
		idle(8);
		rdc(ecic_pkg::IDX_CAP, 16'h2222, "queue capture");
		rdc(ecic_pkg::IDX_HOLD, 16'h1111, "queue holding");
		// Latch mode: forced and modulus-zero latches, then buffers off
		wr(ecic_pkg::IDX_OVW, 8'h00);
		wr(ecic_pkg::IDX_SYS, 8'h03);
		timer_count <= 16'h4444;
		pm.pulse(1, 10);
		pm.pulse(0, 10);
		idle(8);
		wr(ecic_pkg::IDX_FORCE, 8'h10);
		rdc(ecic_pkg::IDX_HOLD + 8'h02, 16'h4444, "forced hold");
		rdc(ecic_pkg::IDX_ACCUM_COUNT_LOW, 16'h0000, "acc cleared");
		timer_count <= 16'h5555;
		pm.toggle(2);
		idle(8);
		mz();
		idle(2);
		rdc(ecic_pkg::IDX_HOLD + 8'h04, 16'h5555, "modulus hold");
		wr(ecic_pkg::IDX_SYS, 8'h01);
		timer_count <= 16'h6666;
		pm.toggle(3);
		idle(8);
		mz();
		wr(ecic_pkg::IDX_FORCE, 8'h10);
		rdc(ecic_pkg::IDX_HOLD + 8'h06, 16'h0000, "buffer off");
		// Accumulator B wraps from all ones; own enables cleared
		wr(ecic_pkg::IDX_ACCUMULATOR_B_CONTROL, 8'h42);
		wr(ecic_pkg::IDX_PACEN, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			wr(ecic_pkg::IDX_ACCUMULATOR_B_FLAGS, 8'h02);
			wr(ecic_pkg::IDX_ACCUM_COUNT_HIGH, 8'hff);
			wr(ecic_pkg::IDX_ACCUM_COUNT_LOW, 8'hff);
			pm.pulse(0, 10);
			idle(8);
			rdc(ecic_pkg::IDX_ACCUMULATOR_B_FLAGS, 16'h0002, "b overflow");
			chk("b irq", 16'h1, 16'(accum_b_irq));
		end
		rdc(ecic_pkg::IDX_ACCUM_COUNT_HIGH, 16'h0000, "b high wrap");
		wr(ecic_pkg::IDX_ACCUMULATOR_B_FLAGS, 8'h02);
		rdc(ecic_pkg::IDX_ACCUMULATOR_B_FLAGS, 16'h0000, "b flag clear");
		chk("b irq off", 16'h0, 16'(accum_b_irq));
		wr(ecic_pkg::IDX_ACCUM_COUNT_LOW, 8'hff);
		wr(ecic_pkg::IDX_ACCUM_COUNT_HIGH, 8'hff);
		pm.pulse(0, 10);
		idle(8);
		rdc(ecic_pkg::IDX_ACCUMULATOR_B_FLAGS, 16'h0002, "b overflow again");
		fast_flag_clear <= 1'b1;
		rd(ecic_pkg::IDX_ACCUM_COUNT_LOW);
		rdc(ecic_pkg::IDX_ACCUMULATOR_B_FLAGS, 16'h0000, "fast clear");
		fast_flag_clear <= 1'b0;
		// Port lines: inputs read the pins, outputs the latch
		pm.set_all(8'h3c);
		wr(ecic_pkg::IDX_DDR, 8'hf0);
		// Byte lane 0 masked: this write must leave the direction alone
		wstrb <= 4'he;
		wr(ecic_pkg::IDX_DDR, 8'h0f);
		wstrb <= 4'hf;
		wr(ecic_pkg::IDX_PORT, 8'ha5);
		idle(4);
		rdc(ecic_pkg::IDX_PORT, 16'h00ac, "port mixed");
		chk("pin oe", 16'h00f0, 16'(pin_oe));
		chk("pin out", 16'h00a0, 16'(pin_out & 8'hf0));
		oc_enable <= 8'h01;
		oc_level <= 8'h01;
		wr(ecic_pkg::IDX_PORT, 8'h00);
		idle(2);
		chk("oc forces oe", 16'h00f1, 16'(pin_oe));
		chk("oc level", 16'h0001, 16'(pin_out & 8'h01));
		rdc(ecic_pkg::IDX_DDR, 16'h00f0, "ddr kept");
		end_of_test();
	end
endmodule
